// File: include/dmr3_pkg.sv
/*
  constants, codes and types for the third mode register block.
  assumes a 100 MHz system clock and a command/address link on the memory clock.
*/
package dmr3_pkg;
  localparam int          MCLK_PERIOD_NS = 10;
  localparam int          TEMP_UPDATE_MS = 32;
  localparam int          TEMP_CNT_W     = 22;
  localparam int          TEMP_UPDATE_CYCLES = (TEMP_UPDATE_MS * 1000000) / MCLK_PERIOD_NS;
  localparam logic [2:0]  MR_SEL_THREE   = 3'h3;
  localparam int          FIELD_W        = 14;
  // field positions inside the stored address word
  localparam int          F_PAGE_LO  = 0;
  localparam int          F_MPR_EN   = 2;
  localparam int          F_GEAR     = 3;
  localparam int          F_PDA      = 4;
  localparam int          F_TEMP     = 5;
  localparam int          F_FGR_LO   = 6;
  localparam int          F_WCL_LO   = 9;
  localparam int          F_FMT_LO   = 11;
  localparam int          F_RSV13    = 13;
  localparam int          A_HALF     = 2;
  localparam int          MPR_TEMP_LO = 3;
  localparam logic [FIELD_W-1:0] FIELD_RESET = 14'h0000;
  localparam logic [1:0]  FMT_SERIAL     = 2'h0;
  localparam logic [1:0]  FMT_PARALLEL   = 2'h1;
  localparam logic [1:0]  FMT_STAGGERED  = 2'h2;
  localparam logic [1:0]  FMT_RESERVED   = 2'h3;
  localparam logic [1:0]  WCL_CODE_4     = 2'h0;
  localparam logic [1:0]  WCL_CODE_5     = 2'h1;
  localparam logic [1:0]  WCL_CODE_6     = 2'h2;
  localparam logic [2:0]  WCL_CK_NONE    = 3'h0;
  localparam logic [2:0]  WCL_CK_4       = 3'h4;
  localparam logic [2:0]  WCL_CK_5       = 3'h5;
  localparam logic [2:0]  WCL_CK_6       = 3'h6;
  localparam logic [2:0]  FGR_FIXED_1X   = 3'h0;
  localparam logic [2:0]  FGR_FIXED_2X   = 3'h1;
  localparam logic [2:0]  FGR_FIXED_4X   = 3'h2;
  localparam logic [2:0]  FGR_OTF_1X2X   = 3'h5;
  localparam logic [2:0]  FGR_OTF_1X4X   = 3'h6;
  localparam logic [1:0]  PAGE_TEMP      = 2'h2;
  localparam logic [1:0]  PAGE_MAKER     = 2'h3;
  localparam logic [1:0]  LOC_TEMP       = 2'h0;
  localparam logic [3:0]  BURST_OF_EIGHT = 4'h8;
  localparam logic [3:0]  BURST_CRC      = 4'ha;

  typedef enum logic [2:0] {
    DMR3_HALF    = 3'b001,
    DMR3_ARMED   = 3'b010,
    DMR3_QUARTER = 3'b100
  } dmr3_gear_type;
endpackage

// File: verilog/dmr3_ctrl.sv
/*
  third mode register of the memory device: link-side command decode on the
  memory clock, field storage and applied settings on the system clock.
  assumes the controller spaces commands at least 8 memory clocks apart and
  that crc_enable and mask_enable come from logic on mclk.
*/
// How it works
// - with crc on, each write burst is ten unit intervals, last two crc
// - mode-set with bank group/bank select code 011 loads the fields
// - bits 12:11 pick serial, parallel or staggered readout; 11 reserved
// - bits 10:9 give crc/mask write latency 4, 5 or 6 clocks
// - bits 8:6 pick fixed 1x/2x/4x or on-the-fly refresh granularity
// - bit 5 posts temperature status into page 2 location 0 bits 4:3
// - posted temperature status is refreshed at least every 32 ms
// - bit 4 enables per-device addressability
// - bit 3 selects half rate or quarter rate gear-down clocking
// - start in half rate; quarter rate needs mode-set then sync pulse
// - bit 2 set sends read data from readout store, clear returns normal
// - in readout mode every read is redirected to the addressed location
// - register contents come back as upper and lower halves
// - reset is accepted in readout mode and clears everything
`timescale 1ns/1ps
module dmr3_ctrl
  import dmr3_pkg::*;
#(
  parameter int TEMP_CYCLES = TEMP_UPDATE_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             ck_link,
  input  wire logic             cs_n,
  input  wire logic             act_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  input  wire logic [1:0]       bg,
  input  wire logic [1:0]       ba,
  input  wire logic [17:0]      addr,
  input  wire logic             sync_pulse,
  input  wire logic [1:0]       temp_sense,
  input  wire logic             crc_enable,
  input  wire logic             mask_enable,
  output logic [1:0]            read_format,
  output logic [2:0]            wcl_clocks,
  output logic [2:0]            refresh_mode,
  output logic                  per_device_en,
  output logic                  quarter_rate,
  output logic                  readout_en,
  output logic [1:0]            readout_page,
  output logic [3:0]            write_burst_len,
  output logic                  code_reserved,
  output logic                  mpr_read,
  output logic [1:0]            mpr_loc,
  output logic                  mpr_upper,
  output logic [7:0]            mpr_data
);
  ////////////////////////////////////////////////////////////////////////////
  // link domain: decode and hold one command word
  typedef struct packed {
    logic                rst_s1;
    logic                rst_s2;
    logic                tog;
    logic                is_mrs;
    logic [FIELD_W-1:0]  word;
  } dmr3_link_type;

  dmr3_link_type l_r;
  dmr3_link_type l_nxt;
  logic          is_mrs_cmd;
  logic          is_rd_cmd;

  always_comb begin
    is_mrs_cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n &&
                 ({bg[0], ba} == MR_SEL_THREE);
    is_rd_cmd  = !cs_n && act_n && ras_n && !cas_n && we_n;
    l_nxt        = l_r;
    l_nxt.rst_s1 = rstn;
    l_nxt.rst_s2 = l_r.rst_s1;
    if (!l_r.rst_s2) begin
      l_nxt.tog    = 1'b0;
      l_nxt.is_mrs = 1'b0;
      l_nxt.word   = FIELD_RESET;
    end else if (is_mrs_cmd || is_rd_cmd) begin
      l_nxt.tog    = !l_r.tog;
      l_nxt.is_mrs = is_mrs_cmd;
      l_nxt.word   = addr[FIELD_W-1:0];
    end
  end

  always_ff @(posedge ck_link) begin
    l_r <= l_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain
  typedef struct packed {
    logic                   tog_s1;
    logic                   tog_s2;
    logic                   tog_s3;
    logic                   sp_s1;
    logic                   sp_s2;
    logic                   sp_s3;
    logic [1:0]             ts_s1;
    logic [1:0]             ts_s2;
    logic [FIELD_W-1:0]     field;
    dmr3_gear_type          gear;
    logic                   quarter;
    logic [1:0]             temp_post;
    logic [TEMP_CNT_W-1:0]  temp_cnt;
    logic [2:0]             crc_mask_write_cmd_latency;
    logic [3:0]             blen;
    logic                   rsv;
    logic                   rd;
    logic [1:0]             loc;
    logic                   upper;
    logic [7:0]             data;
  } dmr3_sys_type;

  localparam logic [TEMP_CNT_W-1:0] TEMP_LAST = TEMP_CNT_W'(TEMP_CYCLES - 1);

  dmr3_sys_type s_r;
  dmr3_sys_type s_nxt;
  logic         cmd_evt;
  logic         sp_rise;
  logic [2:0]   fgr;
  logic [1:0]   fmt;

  always_comb begin
    s_nxt        = s_r;
    cmd_evt      = s_r.tog_s2 != s_r.tog_s3;
    sp_rise      = s_r.sp_s2 && !s_r.sp_s3;
    s_nxt.tog_s1 = l_r.tog;
    s_nxt.tog_s2 = s_r.tog_s1;
    s_nxt.tog_s3 = s_r.tog_s2;
    s_nxt.sp_s1  = sync_pulse;
    s_nxt.sp_s2  = s_r.sp_s1;
    s_nxt.sp_s3  = s_r.sp_s2;
    s_nxt.ts_s1  = temp_sense;
    s_nxt.ts_s2  = s_r.ts_s1;
    s_nxt.rd     = 1'b0;
    // link word is stable here: it changed two syncs ago
    if (cmd_evt && l_r.is_mrs) begin
      s_nxt.field = l_r.word;
    end
    if (cmd_evt && !l_r.is_mrs && s_r.field[F_MPR_EN]) begin
      s_nxt.rd    = 1'b1;
      s_nxt.loc   = l_r.word[1:0];
      s_nxt.upper = l_r.word[A_HALF];
      s_nxt.data  = 8'h00;
      if (s_r.field[F_PAGE_LO+:2] == PAGE_TEMP && l_r.word[1:0] == LOC_TEMP) begin
        s_nxt.data[MPR_TEMP_LO+:2] = s_r.temp_post;
      end
    end
    // periodic post keeps the status younger than the update period
    if (s_r.temp_cnt == TEMP_LAST) begin
      s_nxt.temp_cnt = '0;
      if (s_r.field[F_TEMP]) begin
        s_nxt.temp_post = s_r.ts_s2;
      end
    end else begin
      s_nxt.temp_cnt = TEMP_CNT_W'(s_r.temp_cnt + 1'b1);
    end
    unique case (s_r.gear)
      DMR3_HALF: begin
        if (s_r.field[F_GEAR]) s_nxt.gear = DMR3_ARMED;
      end
      DMR3_ARMED: begin
        if (!s_r.field[F_GEAR]) s_nxt.gear = DMR3_HALF;
        else if (sp_rise) s_nxt.gear = DMR3_QUARTER;
      end
      DMR3_QUARTER: begin
        if (!s_r.field[F_GEAR]) s_nxt.gear = DMR3_HALF;
      end
      default: s_nxt.gear = DMR3_HALF;
    endcase
    // registered copy so the pin needs no decode after the flop
    s_nxt.quarter = s_nxt.gear == DMR3_QUARTER;
    s_nxt.blen = crc_enable ? BURST_CRC : BURST_OF_EIGHT;
    s_nxt.crc_mask_write_cmd_latency  = WCL_CK_NONE;
    if (crc_enable && mask_enable) begin
      unique case (s_r.field[F_WCL_LO+:2])
        WCL_CODE_4: s_nxt.crc_mask_write_cmd_latency = WCL_CK_4;
        WCL_CODE_5: s_nxt.crc_mask_write_cmd_latency = WCL_CK_5;
        WCL_CODE_6: s_nxt.crc_mask_write_cmd_latency = WCL_CK_6;
        default:    s_nxt.crc_mask_write_cmd_latency = WCL_CK_NONE;
      endcase
    end
    fgr = s_r.field[F_FGR_LO+:3];
    fmt = s_r.field[F_FMT_LO+:2];
    s_nxt.rsv = (fmt == FMT_RESERVED) || (s_r.field[F_WCL_LO+:2] == 2'h3) ||
                !(fgr == FGR_FIXED_1X || fgr == FGR_FIXED_2X ||
                  fgr == FGR_FIXED_4X || fgr == FGR_OTF_1X2X ||
                  fgr == FGR_OTF_1X4X) ||
                s_r.field[F_RSV13];
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_r       <= '0;
      s_r.gear  <= DMR3_HALF;
      s_r.blen  <= BURST_OF_EIGHT;
      s_r.field <= FIELD_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign read_format     = s_r.field[F_FMT_LO+:2];
  assign wcl_clocks      = s_r.crc_mask_write_cmd_latency;
  assign refresh_mode    = s_r.field[F_FGR_LO+:3];
  assign per_device_en   = s_r.field[F_PDA];
  assign quarter_rate    = s_r.quarter;
  assign readout_en      = s_r.field[F_MPR_EN];
  assign readout_page    = s_r.field[F_PAGE_LO+:2];
  assign write_burst_len = s_r.blen;
  assign code_reserved   = s_r.rsv;
  assign mpr_read        = s_r.rd;
  assign mpr_loc         = s_r.loc;
  assign mpr_upper       = s_r.upper;
  assign mpr_data        = s_r.data;

  ////////////////////////////////////////////////////////////////////////////
  sequence mrs_seen;
    cmd_evt && l_r.is_mrs;
  endsequence

  sequence gear_sync_seen;
    s_r.gear == DMR3_ARMED && s_r.field[F_GEAR] && sp_rise;
  endsequence

  sequence temp_wrap_seen;
    s_r.temp_cnt == TEMP_LAST && s_r.field[F_TEMP];
  endsequence

  a_mrs_toggle: assert property (@(posedge ck_link) disable iff (!l_r.rst_s2)
    is_mrs_cmd |=> (l_r.tog != $past(l_r.tog)) && l_r.is_mrs)
    else $error("mode-set not captured");
  a_field_load: assert property (@(posedge mclk) disable iff (!rstn)
    mrs_seen |=> s_r.field == $past(l_r.word))
    else $error("fields not loaded by mode-set");
  a_field_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !(cmd_evt && l_r.is_mrs) |=> $stable(s_r.field))
    else $error("fields changed without mode-set");
  a_read_redirect: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_evt && !l_r.is_mrs && readout_en |=> mpr_read && mpr_loc == $past(l_r.word[1:0]))
    else $error("read not redirected");
  a_no_redirect: assert property (@(posedge mclk) disable iff (!rstn)
    !readout_en |=> !mpr_read)
    else $error("redirect outside readout mode");
  a_gear_entry: assert property (@(posedge mclk) disable iff (!rstn)
    s_r.gear == DMR3_HALF |=> !quarter_rate)
    else $error("quarter rate without sync pulse");
  a_gear_sync: assert property (@(posedge mclk) disable iff (!rstn)
    gear_sync_seen |=> quarter_rate)
    else $error("sync pulse did not enter quarter rate");
  a_burst_crc: assert property (@(posedge mclk) disable iff (!rstn)
    crc_enable ##1 crc_enable |-> write_burst_len == BURST_CRC)
    else $error("crc burst not ten");
  a_wcl_map: assert property (@(posedge mclk) disable iff (!rstn)
    crc_enable && mask_enable && s_r.field[F_WCL_LO+:2] == WCL_CODE_5
      |=> wcl_clocks == WCL_CK_5)
    else $error("write latency code mismatch");
  a_temp_fresh: assert property (@(posedge mclk) disable iff (!rstn)
    temp_wrap_seen |=> s_r.temp_post == $past(s_r.ts_s2))
    else $error("temperature post not refreshed");
  a_reset_clear: assert property (@(posedge mclk)
    !rstn |=> !readout_en && !quarter_rate && !mpr_read)
    else $error("reset did not clear state");
endmodule

// File: testbench/dmr3_mc_model.sv
/*
  memory controller model: drives the command/address link on ck_link.
  assumes the caller runs one command at a time; each call includes the idle gap.
*/
`timescale 1ns/1ps
module dmr3_mc_model (
  input  wire logic        ck_link,
  output logic             cs_n,
  output logic             act_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       bg,
  output logic [1:0]       ba,
  output logic [17:0]      addr
);
  initial begin
    cs_n = 1'b1;
    {act_n, ras_n, cas_n, we_n} = 4'hf;
    {bg, ba, addr} = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic [3:0] pins, input logic [2:0] sel, input logic [17:0] a);
    @(posedge ck_link);
    cs_n <= 1'b0;
    {act_n, ras_n, cas_n, we_n} <= pins;
    bg <= {1'b0, sel[2]};
    ba <= sel[1:0];
    addr <= a;
    @(posedge ck_link);
    cs_n <= 1'b1;
    {act_n, ras_n, cas_n, we_n} <= 4'hf;
    addr <= ~a; // released addr and ba pins are inverted so they never keep the last value
    ba <= ~sel[1:0];
    repeat (8) @(posedge ck_link); // keep the 8-clock spacing
  endtask
  // strobes low, select code on bg/ba, reserved bits forced to zero
  task automatic mode_set(input logic [2:0] sel, input logic [13:0] f);
    issue(4'h8, sel, {4'h0, 1'b0, f[12:0]});
  endtask
  task automatic read(input logic [17:0] a);
    issue(4'hd, 3'h0, a);
  endtask
  // crc/mask write latency code picked only from the data rate
  function automatic logic [1:0] wcl_for_rate(input int mts);
    if (mts <= 1600) return 2'h0;
    if (mts <= 2666) return 2'h1;
    return 2'h2;
  endfunction
endmodule

// File: testbench/tb_dram_mode_register_three_ctrl.sv
/*
  self-checking bench for the third mode register block.
  assumes the link model above and a short temperature refresh period.
*/
`timescale 1ns/1ps
module tb_dram_mode_register_three_ctrl;
  import dmr3_pkg::*;
  logic        mclk = 1'b0;
  logic        ck_link = 1'b0;
  logic        rstn = 1'b0;
  logic        sync_pulse = 1'b0;
  logic        crc_enable = 1'b0;
  logic        mask_enable = 1'b0;
  logic [1:0]  temp_sense = 2'h0;
  logic        cs_n, act_n, ras_n, cas_n, we_n, per_device_en, quarter_rate;
  logic        readout_en, code_reserved, mpr_read, mpr_upper;
  logic [1:0]  bg, ba, read_format, readout_page, mpr_loc;
  logic [2:0]  wcl_clocks, refresh_mode;
  logic [3:0]  write_burst_len;
  logic [7:0]  mpr_data;
  logic [17:0] addr;
  logic [13:0] fld;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #5 mclk = ~mclk;
  initial begin
    #1.3;
    forever #3 ck_link = ~ck_link;
  end
  dmr3_mc_model ctl (.ck_link, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .addr);
  dmr3_ctrl #(.TEMP_CYCLES(16)) dut (.mclk, .rstn, .ck_link, .cs_n, .act_n, .ras_n,
    .cas_n, .we_n, .bg, .ba, .addr, .sync_pulse, .temp_sense, .crc_enable, .mask_enable,
    .read_format, .wcl_clocks, .refresh_mode, .per_device_en, .quarter_rate, .readout_en,
    .readout_page, .write_burst_len, .code_reserved, .mpr_read, .mpr_loc, .mpr_upper,
    .mpr_data);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic check_fields;
    logic [2:0] w;
    logic       r;
    w = (crc_enable && mask_enable && fld[10:9] != 2'h3) ? 3'h4 + fld[10:9] : 3'h0;
    r = fld[12:11] == 2'h3 || fld[10:9] == 2'h3 || fld[8:6] == 3'h3 || fld[8:6] == 3'h4;
    r = r || fld[8:6] == 3'h7;
    chk("read_format", fld[12:11], read_format);
    chk("wcl_clocks", w, wcl_clocks);
    chk("refresh_mode", fld[8:6], refresh_mode);
    chk("per_device_en", fld[4], per_device_en);
    chk("readout_en", fld[2], readout_en);
    chk("readout_page", fld[1:0], readout_page);
    chk("code_reserved", r, code_reserved);
    chk("write_burst_len", crc_enable ? 4'ha : 4'h8, write_burst_len);
  endtask
  task automatic mset(input logic [2:0] sel, input logic [13:0] f);
    ctl.mode_set(sel, f);
    if (sel == 3'h3) fld = {1'b0, f[12:0]};
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input logic [17:0] a, input logic hit, input logic [7:0] d);
    int k;
    fork
      ctl.read(a);
    join_none
    for (k = 0; k < 60 && mpr_read !== 1'b1; k++) @(negedge mclk);
    chk("mpr_read", hit, k < 60);
    if (hit) begin
      chk("mpr_loc", a[1:0], mpr_loc);
      chk("mpr_upper", a[2], mpr_upper);
      chk("mpr_data", d, mpr_data);
    end
    wait fork;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [13:0] f;
    logic        c;
    logic        m;
    void'($urandom(27110));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(negedge mclk);
    fld = '0;
    check_fields;
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      c = 1'($urandom);
      m = 1'($urandom);
      crc_enable <= c;
      mask_enable <= m;
      f = 14'($urandom);
      f[12:11] = i[1:0];
      f[10:9] = i[3:2];
      f[8:6] = i[2:0];
      f[3] = 1'b0;
      // readout stays off so the following mode-sets remain legal
      f[2] = 1'b0;
      if (f[1:0] == 2'h3) f[1:0] = 2'h2;
      // nominal data rate steps 1400..3200 MT/s across the loop
      if (c && m) f[10:9] = ctl.wcl_for_rate(1400 + 120 * i);
      mset(3'h3, f);
      check_fields;
    end
    mset(3'h2, 14'h1555);
    check_fields;
    $display("test fields done");
    mset(3'h3, 14'h0008);
    chk("quarter_rate", 1'b0, quarter_rate);
    @(posedge mclk);
    sync_pulse <= 1'b1;
    repeat (3) @(posedge mclk);
    sync_pulse <= 1'b0;
    repeat (6) @(negedge mclk);
    chk("quarter_rate", 1'b1, quarter_rate);
    mset(3'h3, 14'h0000);
    chk("quarter_rate", 1'b0, quarter_rate);
    $display("test gear done");
    rd(18'h000, 1'b0, 8'h00);
    @(posedge mclk);
    temp_sense <= 2'h2;
    // the model never opens a row, so all banks are idle here
    mset(3'h3, 14'h0026);
    check_fields;
    repeat (40) @(negedge mclk);
    rd(18'h004, 1'b1, 8'h10);
    rd(18'h001, 1'b1, 8'h00);
    @(posedge mclk);
    temp_sense <= 2'h1;
    repeat (40) @(negedge mclk);
    rd(18'h000, 1'b1, 8'h08);
    $display("test readout done");
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(negedge mclk);
    fld = '0;
    check_fields;
    chk("quarter_rate", 1'b0, quarter_rate);
    $display("test reset in readout done");
    summarize;
  end
  initial begin
    #200000;
    n_mismatch++;
    summarize;
  end
endmodule
